//--- core/dsr_core.sv
// Dual eight-stage serial shift register with OR-ed shift clocks.
// Assumes every pin is asynchronous to clock; records of each shift
// leave through a buffered valid/ready stream.
module dsr_core #(
  parameter int STAGES    = dsr_pkg::STAGES,
  parameter int REC_DEPTH = dsr_pkg::REC_DEPTH
) (
  input  wire logic                            clock,
  input  wire logic                            arst_n,
  input  wire logic                            common_shift_clock,
  input  wire logic                            clear_n,
  input  wire logic [dsr_pkg::LANES-1:0]       sep_shift_clock,
  input  wire logic [dsr_pkg::LANES-1:0]       select,
  input  wire logic [dsr_pkg::LANES-1:0]       serial_input_a,
  input  wire logic [dsr_pkg::LANES-1:0]       serial_input_b,
  output logic      [dsr_pkg::LANES-1:0]       last_stage_out,
  output logic      [dsr_pkg::LANES-1:0]       last_stage_out_n,
  output logic                                 shift_stall,
  output logic                                 rec_valid,
  input  wire logic                            rec_ready,
  output dsr_pkg::dsr_rec_t                    rec_data
);

  localparam int LANES = dsr_pkg::LANES;

  // Refuse a register length the package constants do not describe
  if (STAGES != dsr_pkg::STAGES || REC_DEPTH < 2) begin : g_chk
    $error("dsr_core: STAGES must match the package, REC_DEPTH >= 2");
  end

  dsr_pkg::dsr_pin_t pin_raw;
  dsr_pkg::dsr_pin_t pin_s1_r;
  dsr_pkg::dsr_pin_t pin_s2_r;
  logic [LANES-1:0]  or_clk;
  logic [LANES-1:0]  or_prev_r;
  logic [LANES-1:0]  edge_hit;
  logic [LANES-1:0]  sel_bit;
  logic [LANES-1:0]  pend_r;
  logic [LANES-1:0]  pend_bit_r;
  logic [LANES-1:0]  go;
  logic [STAGES-1:0] stage_r [LANES];
  logic [LANES-1:0]  new_last;
  logic              clr_on;
  logic              fifo_in_ready;
  logic              push;
  dsr_pkg::dsr_rec_t rec_in;

  // Picks the serial source for one register
  function automatic logic pick_serial(input logic sel, input logic a,
                                       input logic b);
    return sel ? b : a;
  endfunction

  // Gather the pins into one carrier
  always_comb begin
    pin_raw.common_shift_clock = common_shift_clock;
    pin_raw.clear_n            = clear_n;
    for (int i = 0; i < LANES; i++) begin
      pin_raw.lane[i].sep_shift_clock = sep_shift_clock[i];
      pin_raw.lane[i].select          = select[i];
      pin_raw.lane[i].serial_input_a  = serial_input_a[i];
      pin_raw.lane[i].serial_input_b  = serial_input_b[i];
    end
  end

  // Two-flop synchroniser on every pin; clear reads as active at reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign clr_on = !pin_s2_r.clear_n;

  // OR of the own and common clock per register, serial mux per register
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      or_clk[i]  = pin_s2_r.lane[i].sep_shift_clock
                 | pin_s2_r.common_shift_clock;
      sel_bit[i] = pick_serial(pin_s2_r.lane[i].select,
                               pin_s2_r.lane[i].serial_input_a,
                               pin_s2_r.lane[i].serial_input_b);
    end
  end

  // Previous OR level; a rise only after both clocks were low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      or_prev_r <= '1;
    end else begin
      or_prev_r <= or_clk;
    end
  end

  // High on either clock masks the other, so only a low-to-high counts
  assign edge_hit = or_clk & ~or_prev_r;

  // Shifts wait while the record buffer is full
  assign go          = pend_r & {LANES{fifo_in_ready && !clr_on}};
  assign shift_stall = |pend_r && !fifo_in_ready;
  assign push        = |go;

  // Pending shift holds the bit trapped at the edge; later edges
  // arriving while a stalled shift waits are dropped
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend_r     <= '0;
      pend_bit_r <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (clr_on) begin
          pend_r[i] <= 1'b0;
        end else if (edge_hit[i] && (!pend_r[i] || go[i])) begin
          pend_r[i]     <= 1'b1;
          pend_bit_r[i] <= sel_bit[i];
        end else if (go[i]) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // Eight stages per register hold until go; clear wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < LANES; i++) begin
        stage_r[i] <= dsr_pkg::STAGE_RST;
      end
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (clr_on) begin
          stage_r[i] <= dsr_pkg::STAGE_RST;
        end else if (go[i]) begin
          // Bit travels stage 0 to stage 7 in eight shifts
          stage_r[i] <= {stage_r[i][STAGES-2:0], pend_bit_r[i]};
        end
      end
    end
  end

  // Complement kept in its own flop so both outputs are registered
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      last_stage_out_n <= '1;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (clr_on) begin
          last_stage_out_n[i] <= 1'b1;
        end else if (go[i]) begin
          last_stage_out_n[i] <= ~stage_r[i][STAGES-2];
        end
      end
    end
  end

  // True last-stage outputs straight from the stages
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      last_stage_out[i] = stage_r[i][STAGES-1];
      new_last[i]       = stage_r[i][STAGES-2];
    end
  end

  // Record of each shift: which lanes moved and their new last stages
  assign rec_in.shifted    = go;
  assign rec_in.last_stage = (new_last & go) | (last_stage_out & ~go);

  dsr_fifo #(
    .WIDTH (dsr_pkg::REC_WIDTH),
    .DEPTH (REC_DEPTH)
  ) u_rec_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (rec_in),
    .out_valid (rec_valid),
    .out_ready (rec_ready),
    .out_data  (rec_data)
  );

  // Checks on the stage behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_clear_seen;
    clr_on;
  endsequence

  sequence s_stalled_then_room(int i);
    pend_r[i] && !fifo_in_ready && !clr_on ##1 fifo_in_ready && !clr_on;
  endsequence

  for (genvar g = 0; g < LANES; g++) begin : g_chk_lane
    logic       trk_bit_r;
    logic [3:0] trk_cnt_r;

    // Follows one entered bit through eight shifts for the depth check
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        trk_bit_r <= 1'b0;
        trk_cnt_r <= 4'h0;
      end else if (clr_on) begin
        trk_cnt_r <= 4'h0;
      end else if (go[g]) begin
        if (trk_cnt_r == 4'h0) begin
          trk_bit_r <= pend_bit_r[g];
        end
        trk_cnt_r <= (trk_cnt_r == 4'(STAGES - 1)) ? 4'h0
                                                   : trk_cnt_r + 4'h1;
      end
    end

    a_clear_empties: assert property (
      s_clear_seen |=> stage_r[g] == '0 && last_stage_out_n[g])
      else $error("stages not emptied by clear");
    a_shift_moves: assert property (
      go[g] |=> stage_r[g] == {$past(stage_r[g][STAGES-2:0]),
                               $past(pend_bit_r[g])})
      else $error("shift did not move stages by one");
    a_hold_steady: assert property (
      !go[g] && !clr_on |=> stage_r[g] == $past(stage_r[g]))
      else $error("stages changed without a shift");
    a_edge_from_low: assert property (
      edge_hit[g] |-> or_clk[g] && !$past(or_clk[g]))
      else $error("shift edge without rising clock OR");
    a_inhibit_high: assert property (
      pin_s2_r.lane[g].sep_shift_clock
      && $past(pin_s2_r.lane[g].sep_shift_clock) |-> !edge_hit[g])
      else $error("shift taken while a clock stayed high");
    a_mux_capture: assert property (
      edge_hit[g] && !pend_r[g] && !clr_on |=> pend_bit_r[g] ==
        $past(pin_s2_r.lane[g].select ? pin_s2_r.lane[g].serial_input_b
                                      : pin_s2_r.lane[g].serial_input_a))
      else $error("serial bit not from selected input");
    a_true_comp: assert property (
      last_stage_out_n[g] == !last_stage_out[g])
      else $error("complement output mismatch");
    a_stall_release: assert property (
      s_stalled_then_room(g) |-> go[g])
      else $error("pending shift not released on room");
    a_depth_eight: assert property (
      go[g] && trk_cnt_r == 4'(STAGES - 1) |=>
        last_stage_out[g] == trk_bit_r)
      else $error("bit not at last stage after eight shifts");
  end

endmodule // dsr_core

//--- core/dsr_pkg.sv
// Constants and carrier types for the dual serial shift register block.
// Assumes one 250 MHz clock; every pin arrives unsynchronised.
package dsr_pkg;

  // Register geometry
  localparam int STAGES    = 8;
  localparam int LANES     = 2;
  localparam int LAST      = STAGES - 1;
  // Reset and clear value of every stage
  localparam logic [STAGES-1:0] STAGE_RST = 8'h00;
  // Depth of the record buffer
  localparam int REC_DEPTH = 8;
  // Flip-flops in each pin synchroniser
  localparam int SYNC_STAGES = 2;

  // Pins belonging to one register
  typedef struct packed {
    logic sep_shift_clock;
    logic select;
    logic serial_input_a;
    logic serial_input_b;
  } dsr_lane_pin_t;

  // Every pin of the block
  typedef struct packed {
    logic                      common_shift_clock;
    logic                      clear_n;
    dsr_lane_pin_t [LANES-1:0] lane;
  } dsr_pin_t;

  // One buffered record: which lanes shifted and their new last stages
  typedef struct packed {
    logic [LANES-1:0] shifted;
    logic [LANES-1:0] last_stage;
  } dsr_rec_t;

  localparam int REC_WIDTH = $bits(dsr_rec_t);

endpackage : dsr_pkg

//--- core/dsr_fifo.sv
// Small FIFO with a registered read stage, valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
module dsr_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // Refuse shapes the pointer wrap cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("dsr_fifo: DEPTH must be a power of two >= 2, WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    mem_cnt_r;
  logic             out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  logic             push;
  logic             load;
  logic [CW:0]      occupancy;

  // Occupancy counts the output register too, so full is honest
  assign occupancy = {1'b0, mem_cnt_r} + {{CW{1'b0}}, out_valid_r};
  assign in_ready  = occupancy < (CW + 1)'(DEPTH);
  assign push      = in_valid && in_ready;
  assign load      = (mem_cnt_r != '0) && (!out_valid_r || out_ready);
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;

  // Storage array, written only on an accepted push
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      mem_cnt_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + PW'(1);
      if (load) rd_ptr_r <= rd_ptr_r + PW'(1);
      mem_cnt_r <= mem_cnt_r + CW'(push) - CW'(load);
    end
  end

  // Registered read stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else if (load) begin
      out_valid_r <= 1'b1;
      out_data_r  <= mem_r[rd_ptr_r];
    end else if (out_ready) begin
      out_valid_r <= 1'b0;
    end
  end

endmodule // dsr_fifo

//--- test/dsr_far_model.sv
// Far-side model: logic that drives the pins and drains the records.
// Assumes the bench calls its tasks; pins move only at falling edges.
module dsr_far_model (
  input  wire logic       clock,
  output logic            common_shift_clock,
  output logic            clear_n,
  output logic [1:0]      sep_shift_clock,
  output logic [1:0]      select,
  output logic [1:0]      serial_input_a,
  output logic [1:0]      serial_input_b,
  output logic            rec_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_rdy = 1'b0;

  // Idle pin levels
  initial begin
    common_shift_clock = 1'b0;
    clear_n = 1'b1;
    sep_shift_clock = 2'h0;
    select = 2'h0;
    serial_input_a = 2'h0;
    serial_input_b = 2'h0;
    rec_ready = 1'b0;
  end

  // Consumer stalls at random unless held off
  always @(negedge clock) rec_ready <= !hold_rdy && ($urandom_range(0, 2) != 0);

  // One pulse: data set up 2 cycles ahead, high 5 cycles, low 3 cycles
  task automatic pulse(input logic [1:0] sm, input logic cm,
                       input logic [1:0] s, input logic [1:0] a,
                       input logic [1:0] b);
    @(negedge clock);
    select <= s;
    serial_input_a <= a;
    serial_input_b <= b;
    repeat (2) @(negedge clock);
    sep_shift_clock <= sep_shift_clock | sm;
    common_shift_clock <= cm;
    repeat (4) @(negedge clock);
    serial_input_a <= 2'($urandom);
    serial_input_b <= 2'($urandom);
    @(negedge clock);
    sep_shift_clock <= sep_shift_clock & ~sm;
    common_shift_clock <= 1'b0;
    repeat (3) @(negedge clock);
  endtask

  // Holds separate clocks high as an inhibit
  task automatic hold(input logic [1:0] m);
    @(negedge clock);
    sep_shift_clock <= m;
    repeat (3) @(negedge clock);
  endtask

  // Clear pulse, then time for the release to pass the synchroniser
  task automatic clr;
    @(negedge clock);
    clear_n <= 1'b0;
    repeat (4) @(negedge clock);
    clear_n <= 1'b1;
    repeat (4) @(negedge clock);
  endtask
endmodule // dsr_far_model

//--- test/tb_dsr_core.sv
// Self-checking bench for the dual serial shift register core.
// Assumes the far-side model drives pins; a stage model checks results.
module tb_dsr_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clock = 1'b0;
  logic              arst_n = 1'b0;
  logic              common_shift_clock, clear_n, rec_ready;
  logic              shift_stall, rec_valid;
  logic [1:0]        sep_shift_clock, select, serial_input_a, serial_input_b;
  logic [1:0]        last_stage_out, last_stage_out_n, held = 2'h0;
  dsr_pkg::dsr_rec_t rec_data;
  logic [7:0]        mdl [2] = '{8'h00, 8'h00};
  logic [3:0]        rq [$];
  int                mismatches = 0;
  int                compares = 0;

  // 250 MHz clock
  initial forever #2 clock = ~clock;

  dsr_far_model i_far (.clock(clock), .common_shift_clock(common_shift_clock),
    .clear_n(clear_n), .sep_shift_clock(sep_shift_clock), .select(select),
    .serial_input_a(serial_input_a), .serial_input_b(serial_input_b),
    .rec_ready(rec_ready));

  dsr_core i_dut (.clock(clock), .arst_n(arst_n),
    .common_shift_clock(common_shift_clock), .clear_n(clear_n),
    .sep_shift_clock(sep_shift_clock), .select(select),
    .serial_input_a(serial_input_a), .serial_input_b(serial_input_b),
    .last_stage_out(last_stage_out), .last_stage_out_n(last_stage_out_n),
    .shift_stall(shift_stall), .rec_valid(rec_valid),
    .rec_ready(rec_ready), .rec_data(rec_data));

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Last stages against the model, true and complement
  task automatic outs(input logic [1:0] lb);
    chk({2'h0, last_stage_out}, {2'h0, lb});
    chk({2'h0, last_stage_out_n}, {2'h0, ~lb});
  endtask

  // One pulse with random data; stall means the shift must wait
  task automatic step(input logic [1:0] sm, input logic cm, input bit stall);
    logic [1:0] s, a, b, sh, old;
    s = 2'($urandom);
    a = 2'($urandom);
    b = 2'($urandom);
    old = {mdl[1][7], mdl[0][7]};
    sh = (sm | {2{cm}}) & ~held;
    for (int i = 0; i < 2; i++)
      if (sh[i]) mdl[i] = {mdl[i][6:0], s[i] ? b[i] : a[i]};
    rq.push_back({sh, mdl[1][7], mdl[0][7]});
    i_far.pulse(sm, cm, s, a, b);
    if (stall) begin
      outs(old);
      chk({3'h0, shift_stall}, 4'h1);
    end else outs({mdl[1][7], mdl[0][7]});
  endtask

  // Moves the inhibit clocks; a clock that rises shifts its lane once
  task automatic inhibit(input logic [1:0] m);
    logic [1:0] sh;
    sh = m & ~held;
    for (int i = 0; i < 2; i++)
      if (sh[i]) mdl[i] = {mdl[i][6:0],
                           select[i] ? serial_input_b[i]
                                     : serial_input_a[i]};
    if (sh != 2'h0) rq.push_back({sh, mdl[1][7], mdl[0][7]});
    i_far.hold(m);
    held = m;
    repeat (2) @(negedge clock);
    outs({mdl[1][7], mdl[0][7]});
  endtask

  // Every popped record against the expected queue
  always @(posedge clock) begin
    if (arst_n && rec_valid === 1'b1 && rec_ready === 1'b1)
      chk(rec_data, rq.size() > 0 ? rq.pop_front() : 4'hX);
  end

  // Watchdog
  initial begin
    #40000;
    mismatches++;
    test_done();
  end

  // Main sequence
  initial begin
    logic [1:0] sm;
    logic       cm;
    void'($urandom(32'h10B9));
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    outs(2'h0);
    for (int n = 0; n < 28; n++) begin
      sm = 2'($urandom);
      cm = (sm == 2'h0) ? 1'b1 : 1'($urandom);
      step(sm, cm, 1'b0);
    end
    // Lane 0 held high: common pulses move lane 1 only
    inhibit(2'h1);
    for (int n = 0; n < 3; n++) step(2'h0, 1'b1, 1'b0);
    // Clear overrides a held clock and empties both registers
    inhibit(2'h2);
    i_far.clr();
    mdl[0] = 8'h00;
    mdl[1] = 8'h00;
    outs(2'h0);
    inhibit(2'h0);
    for (int n = 0; n < 4; n++) step(2'h3, 1'b0, 1'b0);
    // Record buffer filled until the next shift stalls, then drained
    for (int n = 0; n < 200 && rq.size() > 0; n++) @(negedge clock);
    i_far.hold_rdy = 1'b1;
    repeat (2) @(negedge clock);
    for (int n = 0; n < 8; n++) step(2'h0, 1'b1, 1'b0);
    step(2'h0, 1'b1, 1'b1);
    i_far.hold_rdy = 1'b0;
    repeat (10) @(negedge clock);
    outs({mdl[1][7], mdl[0][7]});
    chk({3'h0, shift_stall}, 4'h0);
    for (int n = 0; n < 200 && rq.size() > 0; n++) @(negedge clock);
    chk(4'(rq.size()), 4'h0);
    test_done();
  end
endmodule // tb_dsr_core
